// File: design/pulse_width_trim_interface.v
// pulse-width coded single-wire trim interface with simulation and fuse select
`timescale 1ns/1ps
`include "trim_defines.vh"

module pulse_width_trim_interface (
	input wire i_clk,
	input wire i_reset,
	input wire i_serial_pulse_input,
	input wire [2:0] i_fuse_gain2,
	input wire [6:0] i_fuse_gain1,
	input wire [7:0] i_fuse_offset,
	input wire i_fuse_master,
	input wire i_fuse_parity,
	input wire i_fuse_test,
	input wire i_fault_overrange,
	input wire i_fault_short,
	input wire i_fault_floating,
	output reg [2:0] o_gain2_code,
	output reg [6:0] o_gain1_code,
	output reg [7:0] o_offset_code,
	output reg o_clamp_force,
	output reg o_parity_error,
	output reg o_blow_strobe,
	output reg [1:0] o_blow_param,
	output reg [7:0] o_blow_value,
	output reg o_sense_strobe,
	output reg [7:0] o_sense_value,
	output reg o_readback_output,
	output reg o_readback_enable
);

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	// an undriven pin is pulled low externally, so idle low loads nothing
	reg [2:0] sync_r;
	reg level_r;
	wire rise = level_r == 1'b0 && sync_r[2] == 1'b1 && sync_r[1] == 1'b1;
	wire fall = level_r == 1'b1 && sync_r[2] == 1'b0 && sync_r[1] == 1'b0;

	always @(posedge i_clk) begin
		if (i_reset) begin
			sync_r <= 3'h0;
			level_r <= 1'b0;
		end else begin
			sync_r <= {sync_r[1:0], i_serial_pulse_input};
			if (sync_r[2] == sync_r[1])
				level_r <= sync_r[2];
		end
	end

	// ----------------------------------------
	// pulse width measurement
	// ----------------------------------------
	// saturating: only the one threshold matters beyond the zero range
	reg [9:0] width_r;
	always @(posedge i_clk) begin
		if (i_reset)
			width_r <= 10'h000;
		else if (rise)
			width_r <= 10'h001;
		else if (level_r && width_r != 10'h3ff)
			width_r <= width_r + 10'h001;
	end

	wire is_zero = width_r >= `ZERO_MIN_CYC && width_r <= `ZERO_MAX_CYC;
	wire is_one = width_r >= `ONE_MIN_CYC;
	// widths between the windows are not loaded
	wire bit_ok = fall && (is_zero || is_one);

	// ----------------------------------------
	// frame shift register
	// ----------------------------------------
	// MSB first, so frame bit 0 is the oldest bit in the top slot
	reg [`FRAME_BITS-1:0] frame_r;
	reg bit_done_r;
	reg [3:0] rd_count_r;
	reg [7:0] rd_shift_r;
	reg rd_mode_r;

	always @(posedge i_clk) begin
		if (i_reset) begin
			frame_r <= {`FRAME_BITS{1'b0}};
			bit_done_r <= 1'b0;
		end else begin
			bit_done_r <= bit_ok && !rd_mode_r;
			// 38-bit window, read mode pulses do not load
			if (bit_ok && !rd_mode_r)
				frame_r <= {frame_r[`FRAME_BITS-2:0], is_one};
		end
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	// start pattern in frame bits 0 to 11
	wire start_ok = frame_r[37:26] == `START_PAT;
	// end pattern in frame bits 26 to 37
	wire end_ok = frame_r[11:0] == `END_PAT;
	wire fill_ok = frame_r[21:20] == `FILLER_PAT;
	wire [1:0] fn = frame_r[25:24];
	wire [1:0] par = frame_r[23:22];
	wire [7:0] val = frame_r[19:12];
	wire frame_ok = bit_done_r && start_ok && end_ok && fill_ok;

	function one_hot8;
		input [7:0] v;
		begin
			one_hot8 = v != 8'h00 && (v & (v - 8'h01)) == 8'h00;
		end
	endfunction

	// ----------------------------------------
	// simulation registers and command effects
	// ----------------------------------------
	reg [2:0] sim_gain2_r;
	reg [6:0] sim_gain1_r;
	reg [7:0] sim_offset_r;

	always @(posedge i_clk) begin
		if (i_reset) begin
			sim_gain2_r <= 3'h0;
			sim_gain1_r <= 7'h00;
			sim_offset_r <= 8'h00;
			o_blow_strobe <= 1'b0;
			o_blow_param <= 2'h0;
			o_blow_value <= 8'h00;
			o_sense_strobe <= 1'b0;
			o_sense_value <= 8'h00;
		end else begin
			o_blow_strobe <= 1'b0;
			o_sense_strobe <= 1'b0;
			// simulate only while master fuse intact
			if (frame_ok && fn == `FN_SIM && !i_fuse_master) begin
				case (par)
				`PAR_GAIN2: sim_gain2_r <= val[2:0];
				`PAR_GAIN1: sim_gain1_r <= val[6:0];
				`PAR_OFFSET: sim_offset_r <= val;
				default: sim_gain2_r <= sim_gain2_r;
				endcase
			end
			// one fuse per frame; no programming after master fuse
			if (frame_ok && fn == `FN_PROG && one_hot8(val) && !i_fuse_master) begin
				o_blow_strobe <= 1'b1;
				o_blow_param <= par;
				o_blow_value <= val;
			end
			if (frame_ok && fn == `FN_SENSE) begin
				o_sense_strobe <= 1'b1;
				o_sense_value <= val;
			end
		end
	end

	// ----------------------------------------
	// read-back shifter
	// ----------------------------------------
	// MSB out first, shift on falling edges, eighth pulse ends
	reg [7:0] rd_load;
	always @* begin
		case (par)
		`PAR_GAIN2: rd_load = {5'h00, i_fuse_gain2};
		`PAR_GAIN1: rd_load = {1'b0, i_fuse_gain1};
		`PAR_OFFSET: rd_load = i_fuse_offset;
		default: rd_load = {5'h00, i_fuse_parity, i_fuse_test, i_fuse_master};
		endcase
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			rd_mode_r <= 1'b0;
			rd_count_r <= 4'h0;
			rd_shift_r <= 8'h00;
			o_readback_output <= 1'b0;
			o_readback_enable <= 1'b0;
		end else begin
			if (frame_ok && fn == `FN_READ) begin
				rd_mode_r <= 1'b1;
				rd_count_r <= 4'h0;
				rd_shift_r <= rd_load;
			end else if (rd_mode_r && fall) begin
				rd_shift_r <= {rd_shift_r[6:0], 1'b0};
				rd_count_r <= rd_count_r + 4'h1;
				if (rd_count_r + 4'h1 == `READ_PULSES)
					rd_mode_r <= 1'b0;
			end
			o_readback_output <= rd_mode_r & rd_shift_r[7];
			o_readback_enable <= rd_mode_r;
		end
	end

	// ----------------------------------------
	// active codes and protection
	// ----------------------------------------
	wire parity_bad = i_fuse_master &&
		((^i_fuse_gain2) ^ (^i_fuse_gain1) ^ (^i_fuse_offset) ^ i_fuse_parity);

	always @(posedge i_clk) begin
		if (i_reset) begin
			o_gain2_code <= 3'h0;
			o_gain1_code <= 7'h00;
			o_offset_code <= 8'h00;
			o_clamp_force <= 1'b0;
			o_parity_error <= 1'b0;
		end else begin
			o_gain2_code <= i_fuse_master ? i_fuse_gain2 : sim_gain2_r;
			o_gain1_code <= i_fuse_master ? i_fuse_gain1 : sim_gain1_r;
			o_offset_code <= i_fuse_master ? i_fuse_offset : sim_offset_r;
			o_parity_error <= parity_bad;
			o_clamp_force <= i_fault_overrange | i_fault_short | i_fault_floating | parity_bad;
		end
	end

endmodule

// File: design/trim_defines.vh
// constants and timing counts for the single-wire trim interface
//
// Contract
// - a high pulse 50 ns to 10 us loads a zero bit
// - a high pulse of 50 us or longer loads a one bit
// - an undriven input reads as steady low, so no bits load
// - a command is one 38-bit frame of six fields
// - frame bits 0 to 11 carry start pattern 1000 0000 0001
// - frame bits 26 to 37 carry end pattern 0111 1111 1110
// - decode fields only when start and end both match exactly
// - function field: 00 sense, 01 simulate, 10 program, 11 read
// - parameter field: 00 gain two, 01 gain one, 10 offset, 11 other
// - filler bits 16 to 17 always carry 10
// - value uses 3 LSBs gain two, 7 LSBs gain one, 8 offset
// - other functions: bit 0 master, bit 1 test, bit 2 parity fuse
// - power-on reset clears the frame shift register
// - master fuse intact selects simulation codes, blown selects fuse codes
// - simulation registers reset to zero codes
// - valid simulate frame writes the selected register, kept until changed
// - simulate frame with parameter 11 is ignored
// - any input fault forces the output clamp, never disabled
// - program frame with one value bit set blows only that fuse
// - read mode shifts fuse value MSB first on falling edges; eighth ends
// - blown master fuse disables simulation permanently
`ifndef TRIM_DEFINES_VH
`define TRIM_DEFINES_VH

`define CLK_PERIOD_PS 100000
`define ZERO_MIN_PS 50000
`define ONE_MIN_PS 50000000
`define ZERO_MAX_PS 10000000
// least time rounds up, at least one cycle
`define ZERO_MIN_CYC ((`ZERO_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ONE_MIN_CYC ((`ONE_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ZERO_MAX_CYC (`ZERO_MAX_PS / `CLK_PERIOD_PS)

`define FRAME_BITS 38
`define START_PAT 12'h801
`define END_PAT 12'h7fe
`define FILLER_PAT 2'h2

`define FN_SENSE 2'h0
`define FN_SIM 2'h1
`define FN_PROG 2'h2
`define FN_READ 2'h3

`define PAR_GAIN2 2'h0
`define PAR_GAIN1 2'h1
`define PAR_OFFSET 2'h2
`define PAR_OTHER 2'h3

`define OTHER_MASTER_BIT 0
`define OTHER_TEST_BIT 1
`define OTHER_PARITY_BIT 2
`define READ_PULSES 4'h8

`endif

// File: bench/trim_chk.sv
// port assertions for the trim interface
`timescale 1ns/1ps
module trim_chk (
	input wire i_clk,
	input wire i_reset,
	input wire i_serial_pulse_input,
	input wire [2:0] i_fuse_gain2,
	input wire [6:0] i_fuse_gain1,
	input wire [7:0] i_fuse_offset,
	input wire i_fuse_master,
	input wire i_fault_overrange,
	input wire i_fault_short,
	input wire i_fault_floating,
	input wire [2:0] o_gain2_code,
	input wire [6:0] o_gain1_code,
	input wire [7:0] o_offset_code,
	input wire o_clamp_force,
	input wire o_blow_strobe,
	input wire [7:0] o_blow_value
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire fault = i_fault_overrange | i_fault_short | i_fault_floating;
	wire [17:0] codes = {o_gain2_code, o_gain1_code, o_offset_code};
	sequence master_held;
		i_fuse_master [*4];
	endsequence
	AST_CLAMP: assert property (fault |-> ##[0:3] o_clamp_force) else $error("clamp late");
	AST_CLAMP_HOLD: assert property (fault && o_clamp_force |=> o_clamp_force) else $error("clamp dropped");
	AST_RST_ZERO: assert property ($fell(i_reset) |-> codes == 18'h0) else $error("codes not zero");
	AST_FUSE_SEL: assert property (master_held |-> codes == {i_fuse_gain2, i_fuse_gain1, i_fuse_offset})
		else $error("fuse codes not selected");
	AST_BLOW_ONEHOT: assert property (o_blow_strobe |-> $onehot(o_blow_value)) else $error("blow not one bit");
	AST_BLOW_LOCK: assert property (o_blow_strobe |-> !i_fuse_master) else $error("blow after master");
	AST_BLOW_PULSE: assert property (o_blow_strobe |=> !o_blow_strobe) else $error("blow too long");
	// with the master fuse intact, codes move only after a frame ends, never while the pin is high
	AST_CODE_QUIET: assert property (!i_fuse_master && $changed(codes) |-> !i_serial_pulse_input)
		else $error("codes moved mid pulse");
endmodule

// File: bench/trim_programmer.sv
// pulse-width programmer model for the single-wire input
`timescale 1ns/1ps
module trim_programmer (
	input wire i_clk,
	output reg o_pin
);
	initial o_pin = 1'b0;
	task send_bit(input b);
		begin
			@(posedge i_clk) #1 o_pin = 1'b1;
			// short zero, long one at its bound
			repeat (b ? 500 : 10) @(posedge i_clk);
			#1 o_pin = 1'b0;
			repeat (100) @(posedge i_clk);
		end
	endtask
	task send_frame(input [37:0] f);
		integer i;
		begin
			for (i = 37; i >= 0; i = i - 1)
				send_bit(f[i]);
		end
	endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the trim interface
`timescale 1ns/1ps
module tb_top;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [2:0] fg2 = 3'h0;
	reg [6:0] fg1 = 7'h0;
	reg [7:0] fof = 8'h0;
	reg fm = 1'b0;
	reg fp = 1'b0;
	reg [2:0] flt = 3'h0;
	wire pin, clamp, perr, blow;
	wire [2:0] g2;
	wire [6:0] g1;
	wire [7:0] ofs, bval;
	wire [1:0] bpar;
	wire rben, rbout, sstb;
	wire [7:0] sval;
	integer senses = 0;
	integer err_count = 0;
	integer samples_checked = 0;
	integer blows = 0;
	integer i;
	always #50 clk = ~clk;
	always @(posedge clk) if (blow === 1'b1) blows <= blows + 1;
	always @(posedge clk) if (sstb === 1'b1) senses <= senses + 1;
	trim_programmer prog (.i_clk(clk), .o_pin(pin));
	pulse_width_trim_interface uut (.i_clk(clk), .i_reset(rst), .i_serial_pulse_input(pin),
		.i_fuse_gain2(fg2), .i_fuse_gain1(fg1), .i_fuse_offset(fof), .i_fuse_master(fm),
		.i_fuse_parity(fp), .i_fuse_test(1'b0), .i_fault_overrange(flt[0]), .i_fault_short(flt[1]),
		.i_fault_floating(flt[2]), .o_gain2_code(g2), .o_gain1_code(g1), .o_offset_code(ofs),
		.o_clamp_force(clamp), .o_parity_error(perr), .o_blow_strobe(blow), .o_blow_param(bpar),
		.o_blow_value(bval), .o_sense_strobe(sstb), .o_sense_value(sval), .o_readback_output(rbout),
		.o_readback_enable(rben));
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task chk(input [8*8:1] name, input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	function [37:0] fr(input [1:0] fn, input [1:0] par, input [7:0] v);
		fr = {12'h801, fn, par, 2'h2, v, 12'h7fe};
	endfunction
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task t_sim;
		begin
			chk("g2", g2, 8'h0);
			chk("ofs", ofs, 8'h0);
			// upper value bits must be dropped
			prog.send_frame(fr(2'h1, 2'h0, 8'hfb));
			chk("g2", g2, 8'h3);
			chk("g1", g1, 8'h0);
			// sense frame only strobes its value, codes untouched
			prog.send_frame(fr(2'h0, 2'h0, 8'h01));
			chk("senses", senses, 8'h1);
			chk("sval", sval, 8'h1);
			chk("g2", g2, 8'h3);
		end
	endtask
	task t_refuse;
		begin
			prog.send_frame(fr(2'h1, 2'h1, 8'h7f) ^ 38'h1);
			chk("g1", g1, 8'h0);
			prog.send_frame(fr(2'h1, 2'h3, 8'hff));
			chk("g2", g2, 8'h3);
			chk("ofs", ofs, 8'h0);
		end
	endtask
	task t_prog;
		begin
			prog.send_frame(fr(2'h2, 2'h2, 8'h40));
			chk("blows", blows, 8'h1);
			chk("bpar", bpar, 8'h2);
			chk("bval", bval, 8'h40);
		end
	endtask
	task t_fault;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				flt = 3'h1 << i;
				tick(4);
				chk("clamp", clamp, 8'h1);
				flt = 3'h0;
				tick(4);
				chk("clamp", clamp, 8'h0);
			end
		end
	endtask
	task t_master;
		begin
			// odd fuse parity, so the parity fuse is set
			fg2 = 3'h5;
			fg1 = 7'h2a;
			fof = 8'h81;
			fp = 1'b1;
			tick(4);
			chk("g2", g2, 8'h3);
			fm = 1'b1;
			tick(4);
			chk("g2", g2, 8'h5);
			chk("g1", g1, 8'h2a);
			chk("ofs", ofs, 8'h81);
			chk("perr", perr, 8'h0);
			// read back the gain two fuses, padded msb first
			prog.send_frame(fr(2'h3, 2'h0, 8'h00));
			chk("rben", rben, 8'h1);
			for (i = 7; i >= 0; i = i - 1) begin
				chk("rbout", rbout, (8'h05 >> i) & 8'h01);
				prog.send_bit(1'b0);
			end
			chk("rben", rben, 8'h0);
			chk("g2", g2, 8'h5);
		end
	endtask
	initial begin
		tick(6);
		rst = 1'b0;
		t_sim;
		t_refuse;
		t_prog;
		t_fault;
		t_master;
		stop_test;
	end
	initial begin
		#9500000;
		err_count = err_count + 1;
		stop_test;
	end
endmodule
bind pulse_width_trim_interface trim_chk chk (.i_clk, .i_reset, .i_serial_pulse_input, .i_fuse_gain2,
	.i_fuse_gain1, .i_fuse_offset, .i_fuse_master, .i_fault_overrange, .i_fault_short, .i_fault_floating,
	.o_gain2_code, .o_gain1_code, .o_offset_code, .o_clamp_force, .o_blow_strobe, .o_blow_value);
